//--- regbuf_pkg.sv
// Constants shared by the registered buffer with parity
package regbuf_pkg;

    localparam int GATED_W    = 22;
    localparam int UNGATED_W  = 6;
    localparam int REG_W      = 28;

    // Register offsets (byte addresses)
    localparam logic [7:0] CONTROL_OFF    = 8'h00;
    localparam logic [7:0] IRQ_STATUS_OFF = 8'h04;
    localparam logic [7:0] IRQ_CLEAR_OFF  = 8'h08;
    localparam logic [7:0] IRQ_ENABLE_OFF = 8'h0C;
    localparam logic [7:0] LINK_STATE_OFF = 8'h10;

    // Control fields
    localparam int CTRL_CHECK_EN_BIT  = 0;
    localparam int CTRL_NO_GATING_BIT = 1;
    localparam logic [1:0] CONTROL_RST = 2'h1;

    // Interrupt fields
    localparam int IRQ_PARITY_BIT  = 0;
    localparam int IRQ_RELEASE_BIT = 1;
    localparam int IRQ_W           = 2;
    localparam logic [1:0] IRQ_ENABLE_RST = 2'h0;

    // Link state fields
    localparam int LS_DRIVING_BIT = 0;
    localparam int LS_LINE_BIT    = 1;
    localparam int LS_GATING_BIT  = 2;
    localparam int LS_RESET_BIT   = 3;
    localparam int LS_COUNT_LSB   = 16;

    // Timing counts in clock cycles
    localparam logic [1:0] ERR_HOLD_CYCLES   = 2'd2;
    localparam logic [1:0] RESET_QUIET_CYCLES = 2'd3;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : regbuf_pkg

//--- parity_error_reporter.sv
// Parity check and open-drain error pulse stretcher
module parity_error_reporter (
    input  wire logic                         clk,
    input  wire logic                         sys_rst,
    input  wire logic                         clear,
    input  wire logic                         check_en,
    input  wire logic [regbuf_pkg::GATED_W-1:0] gated_data,
    input  wire logic                         parity_bit_in,
    output logic                              error_active,
    output logic                              error_pulse,
    output logic                              quiet
);

    logic [1:0] hold_r;
    logic [1:0] quiet_r;
    logic       mismatch;

    // Odd overall parity expected; even count flags an error
    assign mismatch = ~(^{gated_data, parity_bit_in});

    assign error_pulse  = check_en && mismatch && (quiet_r == 2'd0);
    assign error_active = (hold_r != 2'd0);
    assign quiet        = (quiet_r != 2'd0);

    ////////////////////////////////////////////////////////////////////////
    // Blanking after reset
    always_ff @(posedge clk) begin
        if (sys_rst || clear) begin
            quiet_r <= regbuf_pkg::RESET_QUIET_CYCLES;
        end else if (quiet_r != 2'd0) begin
            quiet_r <= quiet_r - 2'd1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Two-cycle low hold, ended early by reset
    always_ff @(posedge clk) begin
        if (sys_rst || clear) begin
            hold_r <= 2'd0;
        end else if (error_pulse) begin
            hold_r <= regbuf_pkg::ERR_HOLD_CYCLES;
        end else if (hold_r != 2'd0) begin
            hold_r <= hold_r - 2'd1;
        end
    end

endmodule : parity_error_reporter

//--- registered_buffer.sv
// Registered 1:2 command/address buffer with parity and AXI4-Lite access
module registered_buffer (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Memory controller side
    input  wire logic        module_reset_n,
    input  wire logic        select_gating_enable,
    input  wire logic        rank_select_a_n,
    input  wire logic        rank_select_b_n,
    input  wire logic [15:0] address_bits,
    input  wire logic [2:0]  bank_address_bits,
    input  wire logic        ras_n,
    input  wire logic        cas_n,
    input  wire logic        we_n,
    input  wire logic [1:0]  clock_enable,
    input  wire logic [1:0]  on_die_term,
    input  wire logic        parity_bit_in,
    // DRAM side, two copies
    output logic      [27:0] registered_outputs_a,
    output logic      [27:0] registered_outputs_b,
    // Shared open-drain error line
    input  wire logic        parity_error_n_i,
    output logic             parity_error_n_o,
    output logic             parity_error_n_oe,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////
    // Functions

    function automatic logic [31:0] merge_bytes(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0]  strb
    );
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge_bytes

    function automatic logic is_mapped(input logic [7:0] addr);
        return (addr == regbuf_pkg::CONTROL_OFF)
            || (addr == regbuf_pkg::IRQ_STATUS_OFF)
            || (addr == regbuf_pkg::IRQ_CLEAR_OFF)
            || (addr == regbuf_pkg::IRQ_ENABLE_OFF)
            || (addr == regbuf_pkg::LINK_STATE_OFF);
    endfunction : is_mapped

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [21:0] gated_r;
    logic [5:0]  ungated_r;
    logic        check_pend_r;
    logic        in_reset_r;
    logic [1:0]  control_r;
    logic [1:0]  irq_status_r;
    logic [1:0]  irq_enable_r;
    logic [15:0] error_count_r;

    logic [21:0] gated_in;
    logic [5:0]  ungated_in;
    logic        rank_active;
    logic        gating_mode;
    logic        gated_update;
    logic        dev_clear;
    logic        error_active;
    logic        error_pulse;
    logic        quiet;
    logic        release_event;

    logic        aw_held_r;
    logic        w_held_r;
    logic [7:0]  aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;
    logic        do_write;
    logic        ar_take;
    logic [31:0] read_word;
    logic [1:0]  clear_mask;
    logic [31:0] control_merged;
    logic [31:0] enable_merged;

    ////////////////////////////////////////////////////////////////////////
    // Input grouping and gating decision

    assign gated_in = {we_n, cas_n, ras_n,
                       bank_address_bits, address_bits};
    assign ungated_in = {on_die_term, clock_enable,
                         rank_select_b_n, rank_select_a_n};

    assign rank_active = !rank_select_a_n || !rank_select_b_n;
    assign gating_mode = select_gating_enable
                      && !control_r[regbuf_pkg::CTRL_NO_GATING_BIT];
    // Gated latches follow the selects only in gating mode
    assign gated_update = !gating_mode || rank_active;
    assign dev_clear = !module_reset_n;

    ////////////////////////////////////////////////////////////////////////
    // Pipeline registers, rising edge of the true clock

    always_ff @(posedge clk) begin
        if (sys_rst || dev_clear) begin
            gated_r <= '0;
        end else if (gated_update) begin
            gated_r <= gated_in;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || dev_clear) begin
            ungated_r <= '0;
        end else begin
            ungated_r <= ungated_in;
        end
    end

    // Marks that the next parity bit belongs to this capture
    always_ff @(posedge clk) begin
        if (sys_rst || dev_clear) begin
            check_pend_r <= 1'b0;
        end else begin
            check_pend_r <= rank_active
                && control_r[regbuf_pkg::CTRL_CHECK_EN_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            in_reset_r <= 1'b1;
        end else begin
            in_reset_r <= dev_clear;
        end
    end

    assign release_event = in_reset_r && !dev_clear && !sys_rst;

    ////////////////////////////////////////////////////////////////////////
    // Outputs: two copies, forced low at once in reset

    always_comb begin
        if (dev_clear) begin
            registered_outputs_a = '0;
            registered_outputs_b = '0;
        end else begin
            registered_outputs_a = {ungated_r, gated_r};
            registered_outputs_b = {ungated_r, gated_r};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Parity check and error line

    parity_error_reporter u_reporter (
        .clk           (clk),
        .sys_rst       (sys_rst),
        .clear         (dev_clear),
        .check_en      (check_pend_r),
        .gated_data    (gated_r),
        .parity_bit_in (parity_bit_in),
        .error_active  (error_active),
        .error_pulse   (error_pulse),
        .quiet         (quiet)
    );

    // Open-drain: only ever pulls low, released in reset
    assign parity_error_n_o  = 1'b0;
    assign parity_error_n_oe = error_active && !dev_clear;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            error_count_r <= '0;
        end else if (error_pulse && error_count_r != 16'hFFFF) begin
            error_count_r <= error_count_r + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel

    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready  = !w_held_r && !bvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign do_write      = aw_held_r && w_held_r && !bvalid_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            w_held_r <= 1'b0;
            w_data_r <= '0;
            w_strb_r <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end else if (do_write) begin
            w_held_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bvalid_r <= 1'b0;
            bresp_r  <= regbuf_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid_r <= 1'b1;
            bresp_r  <= is_mapped(aw_addr_r) ? regbuf_pkg::RESP_OKAY
                                             : regbuf_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control and interrupt registers

    assign control_merged = merge_bytes({30'h0, control_r},
                                        w_data_r, w_strb_r);
    assign enable_merged  = merge_bytes({30'h0, irq_enable_r},
                                        w_data_r, w_strb_r);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            control_r <= regbuf_pkg::CONTROL_RST;
        end else if (do_write && aw_addr_r == regbuf_pkg::CONTROL_OFF) begin
            control_r <= control_merged[1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_enable_r <= regbuf_pkg::IRQ_ENABLE_RST;
        end else if (do_write
                     && aw_addr_r == regbuf_pkg::IRQ_ENABLE_OFF) begin
            irq_enable_r <= enable_merged[1:0];
        end
    end

    always_comb begin
        if (do_write && aw_addr_r == regbuf_pkg::IRQ_CLEAR_OFF
                && w_strb_r[0]) begin
            clear_mask = w_data_r[1:0];
        end else begin
            clear_mask = 2'b00;
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_status_r <= '0;
        end else begin
            irq_status_r <= (irq_status_r & ~clear_mask)
                | {release_event, error_pulse};
        end
    end

    assign irq = |(irq_status_r & irq_enable_r);

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel

    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
    assign ar_take       = s_axi_arvalid && !rvalid_r;

    always_comb begin
        read_word = 32'h0000_0000;
        if (s_axi_araddr == regbuf_pkg::CONTROL_OFF) begin
            read_word[1:0] = control_r;
        end else if (s_axi_araddr == regbuf_pkg::IRQ_STATUS_OFF) begin
            read_word[1:0] = irq_status_r;
        end else if (s_axi_araddr == regbuf_pkg::IRQ_ENABLE_OFF) begin
            read_word[1:0] = irq_enable_r;
        end else if (s_axi_araddr == regbuf_pkg::LINK_STATE_OFF) begin
            read_word[regbuf_pkg::LS_DRIVING_BIT] = parity_error_n_oe;
            read_word[regbuf_pkg::LS_LINE_BIT]    = parity_error_n_i;
            read_word[regbuf_pkg::LS_GATING_BIT]  = gating_mode;
            read_word[regbuf_pkg::LS_RESET_BIT]   = dev_clear || quiet;
            read_word[31:regbuf_pkg::LS_COUNT_LSB] = error_count_r;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rvalid_r <= 1'b0;
            rdata_r  <= '0;
            rresp_r  <= regbuf_pkg::RESP_OKAY;
        end else if (ar_take) begin
            rvalid_r <= 1'b1;
            rdata_r  <= read_word;
            rresp_r  <= is_mapped(s_axi_araddr) ? regbuf_pkg::RESP_OKAY
                                                : regbuf_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

endmodule : registered_buffer

//--- registered_buffer_props.sv
// Port checker for the registered buffer
module registered_buffer_props (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        module_reset_n,
    input wire logic        select_gating_enable,
    input wire logic        rank_select_a_n,
    input wire logic        rank_select_b_n,
    input wire logic [15:0] address_bits,
    input wire logic [2:0]  bank_address_bits,
    input wire logic        ras_n,
    input wire logic        cas_n,
    input wire logic        we_n,
    input wire logic [1:0]  clock_enable,
    input wire logic [1:0]  on_die_term,
    input wire logic        parity_bit_in,
    input wire logic [27:0] registered_outputs_a,
    input wire logic [27:0] registered_outputs_b,
    input wire logic        parity_error_n_o,
    input wire logic        parity_error_n_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////
    logic [21:0] gin;
    logic        sel;
    logic        err_raw;
    logic        err_now;
    logic [21:0] prev_gated_r;
    logic        prev_sel_r;
    logic [2:0]  up_cnt_r;
    assign gin = {we_n, cas_n, ras_n, bank_address_bits, address_bits};
    assign sel = !rank_select_a_n || !rank_select_b_n;
    assign err_raw = prev_sel_r && !(^{prev_gated_r, parity_bit_in});
    assign err_now = err_raw && (up_cnt_r >= 3'h3);
    // Previous capture for pairing with parity
    always_ff @(posedge clk) begin
        prev_gated_r <= gin;
        prev_sel_r   <= sel && module_reset_n && !sys_rst;
    end
    // Cycles since any reset, saturating
    always_ff @(posedge clk) begin
        if (sys_rst || !module_reset_n)
            up_cnt_r <= 3'h0;
        else if (up_cnt_r != 3'h7)
            up_cnt_r <= up_cnt_r + 3'h1;
    end
    ////////////////////////////////////////////////////////////////////////
    a_copies_equal: assert property (
        registered_outputs_a == registered_outputs_b)
        else $error("output copies differ");
    a_reset_forces: assert property (
        !module_reset_n |-> registered_outputs_a == 28'h000_0000
        && !parity_error_n_oe) else $error("reset not forcing outputs");
    a_ungated_follow: assert property (
        module_reset_n && $past(module_reset_n) && !$past(sys_rst)
        |-> registered_outputs_a[27:22] == $past({on_die_term,
        clock_enable, rank_select_b_n, rank_select_a_n}))
        else $error("ungated outputs wrong");
    a_gate_hold: assert property (
        module_reset_n && $past(module_reset_n) && !$past(sys_rst)
        && $past(select_gating_enable && !sel)
        |-> $stable(registered_outputs_a[21:0]))
        else $error("gated outputs changed while deselected");
    a_gate_load: assert property (
        module_reset_n && $past(module_reset_n) && !$past(sys_rst)
        && $past(!select_gating_enable || sel)
        |-> registered_outputs_a[21:0] == $past(gin))
        else $error("gated outputs not loaded");
    a_quiet_release: assert property (
        $rose(module_reset_n) |-> !parity_error_n_oe [*4])
        else $error("error raised during blanking");
    a_err_raise: assert property (
        err_now |=> parity_error_n_oe || !module_reset_n)
        else $error("parity mismatch not flagged");
    a_err_cause: assert property (
        $rose(parity_error_n_oe) |-> $past(err_raw))
        else $error("error without mismatch");
    a_err_hold: assert property (
        $rose(parity_error_n_oe) |=> parity_error_n_oe || !module_reset_n)
        else $error("error pulse too short");
    a_err_release: assert property (
        $rose(parity_error_n_oe) ##1 (!err_raw && !$past(err_raw))
        |=> !parity_error_n_oe) else $error("error pulse too long");
    a_open_drain: assert property (
        !parity_error_n_o) else $error("error line driven high");
    c_error: cover property ($rose(parity_error_n_oe));
    c_hold: cover property ($past(select_gating_enable && !sel));
    c_release: cover property ($rose(module_reset_n));
endmodule : registered_buffer_props

bind registered_buffer registered_buffer_props u_props (.*);

//--- ctrl_model.sv
// Memory controller model with delayed parity and error line monitor
module ctrl_model (
    input  wire logic        clk,
    input  wire logic [21:0] cmd,
    input  wire logic        corrupt,
    input  wire logic        parity_error_n_i,
    output logic [15:0]      address_bits,
    output logic [2:0]       bank_address_bits,
    output logic             ras_n,
    output logic             cas_n,
    output logic             we_n,
    output logic             parity_bit_in,
    output logic             error_seen
);
    assign {we_n, cas_n, ras_n, bank_address_bits, address_bits} = cmd;
    // Odd parity one clock after its command
    always_ff @(posedge clk) begin
        parity_bit_in <= ~^cmd ^ corrupt;
    end
    // Low line means an error somewhere
    assign error_seen = !parity_error_n_i;
endmodule : ctrl_model

//--- registered_buffer_tb_top.sv
// Self-checking testbench for the registered buffer
module registered_buffer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
    typedef struct packed {
        logic        g;
        logic [1:0]  s;
        logic [21:0] d;
        logic        bad;
        logic [21:0] q;
        logic        e;
    } row_t;
    logic        clk, sys_rst, module_reset_n, select_gating_enable;
    logic        rank_select_a_n, rank_select_b_n, corrupt, error_seen;
    logic [21:0] cmd;
    logic [15:0] address_bits;
    logic [2:0]  bank_address_bits;
    logic        ras_n, cas_n, we_n, parity_bit_in, irq;
    logic [1:0]  clock_enable, on_die_term;
    logic [27:0] registered_outputs_a, registered_outputs_b, ex;
    logic        parity_error_n_i, parity_error_n_o, parity_error_n_oe;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    int          n_fail, checked;
    row_t        rows [6] = '{
        '{1'h1, 2'h2, 22'h2a_5a5a, 1'h0, 22'h2a_5a5a, 1'h0},
        '{1'h1, 2'h1, 22'h15_a5a5, 1'h1, 22'h15_a5a5, 1'h1},
        '{1'h1, 2'h3, 22'h3f_ffff, 1'h1, 22'h15_a5a5, 1'h0},
        '{1'h0, 2'h3, 22'h00_0001, 1'h0, 22'h00_0001, 1'h0},
        '{1'h0, 2'h0, 22'h3f_ffff, 1'h1, 22'h3f_ffff, 1'h1},
        '{1'h1, 2'h3, 22'h00_0000, 1'h0, 22'h3f_ffff, 1'h0}};
    ////////////////////////////////////////////////////////////////////////
    assign parity_error_n_i = !parity_error_n_oe;
    registered_buffer DUT (.*);
    ctrl_model u_ctrl (.*);
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done
    // One AXI4-Lite write or read
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int   n;
        logic aw_t, w_t, ar_t, fin;
        n = 0;
        fin = 1'h0;
        @(posedge clk);
        if (w) begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'h1;
            s_axi_wvalid <= 1'h1;
            s_axi_bready <= 1'h1;
        end else begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'h1;
            s_axi_rready <= 1'h1;
        end
        while (!fin && n < 50) begin
            @(negedge clk);
            aw_t = s_axi_awvalid && s_axi_awready;
            w_t = s_axi_wvalid && s_axi_wready;
            ar_t = s_axi_arvalid && s_axi_arready;
            fin = w ? s_axi_bvalid : s_axi_rvalid;
            rd = s_axi_rdata;
            rsp = w ? s_axi_bresp : s_axi_rresp;
            @(posedge clk);
            if (aw_t) s_axi_awvalid <= 1'h0;
            if (w_t) s_axi_wvalid <= 1'h0;
            if (ar_t) s_axi_arvalid <= 1'h0;
            if (fin) s_axi_bready <= 1'h0;
            if (fin) s_axi_rready <= 1'h0;
            n++;
        end
        if (!fin) begin
            n_fail++;
            test_done();
        end
    endtask : bus
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {n_fail, checked} = 64'h0;
        {sys_rst, module_reset_n, select_gating_enable} = 3'h7;
        {rank_select_a_n, rank_select_b_n, corrupt} = 3'h6;
        {cmd, clock_enable, on_die_term} = 26'h000_0000;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        repeat (2) @(posedge clk);
        sys_rst <= 1'h0;
        bus(1'h0, regbuf_pkg::CONTROL_OFF, 32'h0);
        `CHK(rd, 32'h0000_0001)
        bus(1'h0, 8'h20, 32'h0);
        `CHK(rsp, regbuf_pkg::RESP_SLVERR)
        `CHK(rd, 32'h0000_0000)
        foreach (rows[i]) begin
            @(posedge clk);
            select_gating_enable <= rows[i].g;
            {rank_select_b_n, rank_select_a_n} <= rows[i].s;
            cmd <= rows[i].d;
            corrupt <= rows[i].bad;
            clock_enable <= 2'(i);
            on_die_term <= ~2'(i);
            @(posedge clk);
            {rank_select_b_n, rank_select_a_n} <= 2'h3;
            corrupt <= 1'h0;
            ex = {~2'(i), 2'(i), rows[i].s, rows[i].q};
            #1;
            `CHK(registered_outputs_a, ex)
            `CHK(registered_outputs_b, ex)
            @(posedge clk);
            #1;
            `CHK(parity_error_n_oe, rows[i].e)
            `CHK(error_seen, rows[i].e)
            @(posedge clk);
            #1;
            `CHK(parity_error_n_oe, rows[i].e)
            @(posedge clk);
            #1;
            `CHK(parity_error_n_oe, 1'h0)
        end
        `CHK(irq, 1'h0)
        bus(1'h0, regbuf_pkg::IRQ_STATUS_OFF, 32'h0);
        `CHK(rd[0], 1'h1)
        bus(1'h1, regbuf_pkg::IRQ_ENABLE_OFF, 32'h0000_0001);
        #1;
        `CHK(irq, 1'h1)
        bus(1'h1, regbuf_pkg::IRQ_CLEAR_OFF, 32'h0000_0001);
        #1;
        `CHK(irq, 1'h0)
        bus(1'h1, regbuf_pkg::CONTROL_OFF, 32'h0);
        bus(1'h0, regbuf_pkg::CONTROL_OFF, 32'h0);
        `CHK(rd, 32'h0000_0000)
        bus(1'h1, regbuf_pkg::CONTROL_OFF, 32'h0000_0001);
        // Two bad commands back to back stretch the pulse
        @(posedge clk);
        {rank_select_b_n, rank_select_a_n, corrupt} <= 3'h5;
        repeat (2) @(posedge clk);
        {rank_select_b_n, rank_select_a_n, corrupt} <= 3'h6;
        repeat (3) begin
            #1;
            `CHK(parity_error_n_oe, 1'h1)
            @(posedge clk);
        end
        #1;
        `CHK(parity_error_n_oe, 1'h0)
        // Reset cuts an error short and overrides selects
        @(posedge clk);
        {rank_select_b_n, rank_select_a_n, corrupt} <= 3'h5;
        @(posedge clk);
        {rank_select_b_n, rank_select_a_n, corrupt} <= 3'h4;
        @(posedge clk);
        #1;
        `CHK(parity_error_n_oe, 1'h1)
        @(posedge clk);
        module_reset_n <= 1'h0;
        #1;
        `CHK(parity_error_n_oe, 1'h0)
        `CHK(registered_outputs_a, 28'h000_0000)
        @(posedge clk);
        {module_reset_n, corrupt} <= 2'h3;
        @(posedge clk);
        {rank_select_b_n, rank_select_a_n, corrupt} <= 3'h6;
        repeat (4) begin
            @(posedge clk);
            #1;
            `CHK(parity_error_n_oe, 1'h0)
        end
        // Forced non-gating, line idle, five errors counted
        bus(1'h1, regbuf_pkg::CONTROL_OFF, 32'h0000_0002);
        bus(1'h0, regbuf_pkg::LINK_STATE_OFF, 32'h0);
        `CHK(rd, 32'h0005_0002)
        test_done();
    end
endmodule : registered_buffer_tb_top
